// *** core/scm_pkg.sv ***
`default_nettype none
package scm_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned STRAP_SETTLE_NS = 1000;
	// Least time, so round up
	localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] SETTLE_COUNT = 16'(STRAP_SETTLE_CYC);

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MGN_HIGH = 8'h04;
	localparam logic [7:0] REG_MGN_LOW = 8'h08;
	localparam logic [7:0] REG_RATE = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_TARGET = 8'h14;
	localparam logic [7:0] REG_NOMINAL = 8'h18;
	localparam logic [7:0] REG_STRAP = 8'h1C;

	localparam int unsigned CTRL_SW_EN_BIT = 0;
	localparam int unsigned CTRL_CMD_LSB = 1;
	localparam int unsigned STS_CLAMP_BIT = 0;
	localparam int unsigned STS_SETTLED_BIT = 1;
	localparam int unsigned STS_SRC_SW_BIT = 2;
	localparam int unsigned STS_RUN_BIT = 3;
	localparam int unsigned STS_CMD_LSB = 4;
	localparam int unsigned STS_FAULT_BIT = 6;
	localparam int unsigned STRAP_TRK_LSB = 8;
	localparam int unsigned STRAP_TRK_EN_BIT = 12;

	localparam logic [15:0] RATE_RESET = 16'h0001;

	// ****************************************
	// Margin and strap decoding
	// ****************************************
	typedef enum logic [1:0] {
		MGN_NOMINAL = 2'h0,
		MGN_HIGH = 2'h1,
		MGN_LOW = 2'h2
	} scm_mgn_t;

	typedef enum logic [1:0] {
		ASTRAP_LOW = 2'h0,
		ASTRAP_OPEN = 2'h1,
		ASTRAP_HIGH = 2'h2,
		ASTRAP_RES = 2'h3
	} scm_astrap_t;

	typedef enum logic [2:0] {
		PH_SETTLE = 3'h1,
		PH_LATCH = 3'h2,
		PH_RUN = 3'h4
	} scm_phase_t;

	localparam logic [6:0] ADDR_LOW = 7'h20;
	localparam logic [6:0] ADDR_OPEN = 7'h21;
	localparam logic [6:0] ADDR_HIGH = 7'h22;
	localparam logic [6:0] ADDR_MAX = 7'h3D;
	localparam logic [4:0] ADDR_RES_COUNT = 5'h1E;

	localparam int unsigned TRK_RATIO_BIT = 2;
	localparam int unsigned TRK_LIMIT_BIT = 1;
	localparam int unsigned TRK_FOLLOW_BIT = 0;
	localparam logic [4:0] CFG_TRK_FIRST = 5'h0F;
	localparam logic [4:0] CFG_TRK_LAST = 5'h11;

	localparam logic [15:0] MARGIN_DIV = 16'h0014;
	localparam logic [15:0] CEILING_DIV = 16'h000A;

endpackage
`default_nettype wire

// *** core/scm_sync.sv ***
`default_nettype none
module scm_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic core_clk, // System clock
	input wire logic reset, // Async reset, active high
	input wire logic [WIDTH-1:0] d, // Asynchronous inputs
	output logic [WIDTH-1:0] q // Synchronised copy
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} scm_sync_state_t;

	scm_sync_state_t state_ff;
	scm_sync_state_t nxt_state;

	// ****************************************
	// Two-stage synchroniser
	// ****************************************
	// First stage feeds only the second stage
	always_comb begin
		nxt_state.meta = d;
		nxt_state.stable = state_ff.meta;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign q = state_ff.stable;

endmodule
`default_nettype wire

// *** core/scm_ramp.sv ***
`default_nettype none
module scm_ramp (
	input wire logic core_clk, // System clock
	input wire logic reset, // Async reset, active high
	input wire logic load, // Force value, one cycle
	input wire logic [15:0] load_val, // Value forced by load
	input wire logic run, // Stepping allowed
	input wire logic [15:0] goal, // Selected target
	input wire logic [15:0] rate, // Cycles per step
	output logic [15:0] cur, // Present target
	output logic at_goal // Present equals goal
);

	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] div;
	} scm_ramp_state_t;

	scm_ramp_state_t state_ff;
	scm_ramp_state_t nxt_state;
	logic step_en;

	// ****************************************
	// Step divider and stepper
	// ****************************************
	// Rate zero behaves as one step a cycle
	assign step_en = (state_ff.div + 16'h0001 >= rate);

	always_comb begin
		nxt_state = state_ff;
		if (load) begin
			nxt_state.cur = load_val;
			nxt_state.div = '0;
		end else if (run && state_ff.cur != goal) begin
			if (step_en) begin
				nxt_state.div = '0;
				if (goal > state_ff.cur) begin
					nxt_state.cur = state_ff.cur + 16'h0001;
				end else begin
					nxt_state.cur = state_ff.cur - 16'h0001;
				end
			end else begin
				nxt_state.div = state_ff.div + 16'h0001;
			end
		end else begin
			nxt_state.div = '0;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign cur = state_ff.cur;
	assign at_goal = (state_ff.cur == goal);

endmodule
`default_nettype wire

// *** core/scm_top.sv ***
// Overview of operation
// - Margin pin sampled continuously as three levels
// - Margin command from pin or software
// - Command high selects upper margin limit
// - Command low selects lower margin limit
// - Default limits nominal plus/minus five percent
// - Limits clamped at nominal plus ten percent
// - Limits, command, rate written independently
// - Soft-start strap decodes tracking ratio
// - Tracking code selects upper track limit
// - Tracking code selects ramp-down behaviour
// - Address strap low/open/high gives 0x20-0x22
// - Thirty resistor codes give 0x20-0x3D
// - Address is seven bits, right-justified
// - Management port is I2C/SMBus compatible
// - Alert line lets host skip polling
// - Event bus pins share one wire
// - Tracking ignores soft-start delay and ramp
// - Tracking active only with config strap
`default_nettype none
module scm_top (
	input wire logic core_clk, // System clock, 100 MHz
	input wire logic reset, // Async reset, active high
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic margin_select_hi, // Margin pin above upper threshold
	input wire logic margin_select_lo, // Margin pin below lower threshold
	input wire logic [15:0] nominal_voltage_strap, // Nominal set point code
	input wire logic [1:0] address_strap_mode, // Low, open, high or resistor
	input wire logic [4:0] address_strap_rindex, // Resistor index on address strap
	input wire logic [3:0] ss_strap_rindex, // Soft-start strap resistor index
	input wire logic [4:0] cfg_strap_rindex, // Config strap index
	input wire logic power_good, // Output in regulation
	input wire logic fault_event, // Fault level from monitors
	output logic alert_line_o, // Alert pin drive value
	output logic alert_line_oe_n, // Alert pin enable, low drives
	output logic [15:0] target_code, // Output target to loop
	output logic target_settled, // Target equals selection
	output logic [6:0] smbus_addr, // Decoded device address
	output logic strap_valid, // Straps latched
	output logic track_enable, // Tracking active
	output logic track_ratio_half, // Tracking ratio 50 percent
	output logic track_limit_track_reference_input, // Upper limit is track reference
	output logic track_follow_down, // Output follows reference down
	output logic track_hold_no_decrease, // Decrease blocked until power-good
	output logic softstart_ignore // Soft-start settings unused
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		scm_pkg::scm_phase_t phase;
		logic [15:0] settle;
		logic [15:0] nominal;
		logic [6:0] addr;
		logic [3:0] trk_code;
		logic trk_en;
		logic sw_en;
		scm_pkg::scm_mgn_t sw_cmd;
		logic [15:0] mgn_high;
		logic [15:0] mgn_low;
		logic [15:0] rate;
		logic clamp_flag;
		logic alert;
		logic [31:0] rdata;
	} scm_top_state_t;

	scm_top_state_t state_ff;
	scm_top_state_t nxt_state;

	logic [35:0] pins_raw;
	logic [35:0] pins_sync;
	logic mgn_hi_s;
	logic mgn_lo_s;
	logic [15:0] nom_s;
	logic [1:0] amode_s;
	logic [4:0] aidx_s;
	logic [3:0] ss_s;
	logic [4:0] cfg_s;
	logic pg_s;
	logic fault_s;

	scm_pkg::scm_mgn_t pin_cmd;
	scm_pkg::scm_mgn_t active_cmd;
	logic [15:0] ceiling;
	logic [15:0] goal;
	logic [15:0] ramp_cur;
	logic ramp_at_goal;
	logic ramp_load;
	logic running;
	logic [15:0] wr_val;
	logic [15:0] wr_clamped;
	logic [31:0] status_word;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] clamp_to(input logic [15:0] value, input logic [15:0] limit);
		clamp_to = (value > limit) ? limit : value;
	endfunction

	function automatic logic [15:0] ceiling_of(input logic [15:0] nom);
		logic [16:0] sum;
		sum = {1'b0, nom} + {1'b0, nom / scm_pkg::CEILING_DIV};
		// Saturate rather than wrap near full scale
		ceiling_of = sum[16] ? 16'hFFFF : sum[15:0];
	endfunction

	function automatic logic [6:0] decode_addr(input logic [1:0] mode, input logic [4:0] idx);
		case (mode)
			scm_pkg::ASTRAP_LOW: decode_addr = scm_pkg::ADDR_LOW;
			scm_pkg::ASTRAP_OPEN: decode_addr = scm_pkg::ADDR_OPEN;
			scm_pkg::ASTRAP_HIGH: decode_addr = scm_pkg::ADDR_HIGH;
			default: begin
				if (idx < scm_pkg::ADDR_RES_COUNT) begin
					decode_addr = scm_pkg::ADDR_LOW + {2'h0, idx};
				end else begin
					decode_addr = scm_pkg::ADDR_MAX;
				end
			end
		endcase
	endfunction

	// ****************************************
	// Pin synchronisation
	// ****************************************
	assign pins_raw = {margin_select_hi, margin_select_lo, nominal_voltage_strap, address_strap_mode,
		address_strap_rindex, ss_strap_rindex, cfg_strap_rindex, power_good, fault_event};

	scm_sync #(
		.WIDTH(36)
	) u_pin_sync (
		.core_clk(core_clk),
		.reset(reset),
		.d(pins_raw),
		.q(pins_sync)
	);

	assign {mgn_hi_s, mgn_lo_s, nom_s, amode_s, aidx_s, ss_s, cfg_s, pg_s, fault_s} = pins_sync;

	// ****************************************
	// Margin command selection
	// ****************************************
	// three-level pin decode
	always_comb begin
		if (mgn_hi_s && !mgn_lo_s) begin
			pin_cmd = scm_pkg::MGN_HIGH;
		end else if (mgn_lo_s && !mgn_hi_s) begin
			pin_cmd = scm_pkg::MGN_LOW;
		end else begin
			pin_cmd = scm_pkg::MGN_NOMINAL;
		end
	end

	assign active_cmd = state_ff.sw_en ? state_ff.sw_cmd : pin_cmd;
	assign ceiling = ceiling_of(state_ff.nominal);
	assign running = (state_ff.phase == scm_pkg::PH_RUN);

	always_comb begin
		case (active_cmd)
			scm_pkg::MGN_HIGH: goal = state_ff.mgn_high;
			scm_pkg::MGN_LOW: goal = state_ff.mgn_low;
			default: goal = state_ff.nominal;
		endcase
		goal = clamp_to(goal, ceiling);
	end

	assign ramp_load = (state_ff.phase == scm_pkg::PH_LATCH);

	scm_ramp u_ramp (
		.core_clk(core_clk),
		.reset(reset),
		.load(ramp_load),
		.load_val(nom_s),
		.run(running),
		.goal(goal),
		.rate(state_ff.rate),
		.cur(ramp_cur),
		.at_goal(ramp_at_goal)
	);

	// ****************************************
	// Register access
	// ****************************************
	assign wr_val = reg_wdata[15:0];
	assign wr_clamped = clamp_to(wr_val, ceiling);

	always_comb begin
		status_word = '0;
		status_word[scm_pkg::STS_CLAMP_BIT] = state_ff.clamp_flag;
		status_word[scm_pkg::STS_SETTLED_BIT] = ramp_at_goal && running;
		status_word[scm_pkg::STS_SRC_SW_BIT] = state_ff.sw_en;
		status_word[scm_pkg::STS_RUN_BIT] = running;
		status_word[scm_pkg::STS_CMD_LSB +: 2] = active_cmd;
		status_word[scm_pkg::STS_FAULT_BIT] = fault_s;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_state.rdata = '0;

		case (state_ff.phase)
			scm_pkg::PH_SETTLE: begin
				// Let strap levels settle before capture
				if (state_ff.settle >= scm_pkg::SETTLE_COUNT) begin
					nxt_state.phase = scm_pkg::PH_LATCH;
				end else begin
					nxt_state.settle = state_ff.settle + 16'h0001;
				end
			end
			scm_pkg::PH_LATCH: begin
				nxt_state.nominal = nom_s;
				nxt_state.addr = decode_addr(amode_s, aidx_s);
				nxt_state.trk_code = ss_s;
				nxt_state.trk_en = (cfg_s >= scm_pkg::CFG_TRK_FIRST) && (cfg_s <= scm_pkg::CFG_TRK_LAST);
				nxt_state.mgn_high = clamp_to(nom_s + nom_s / scm_pkg::MARGIN_DIV, ceiling_of(nom_s));
				nxt_state.mgn_low = nom_s - nom_s / scm_pkg::MARGIN_DIV;
				nxt_state.phase = scm_pkg::PH_RUN;
			end
			scm_pkg::PH_RUN: begin
				nxt_state.phase = scm_pkg::PH_RUN;
			end
			default: begin
				nxt_state.phase = scm_pkg::PH_SETTLE;
			end
		endcase

		// host path behind SMBus front end
		if (reg_wr && running) begin
			case (reg_addr)
				scm_pkg::REG_CTRL: begin
					nxt_state.sw_en = reg_wdata[scm_pkg::CTRL_SW_EN_BIT];
					if (reg_wdata[scm_pkg::CTRL_CMD_LSB +: 2] == scm_pkg::MGN_HIGH) begin
						nxt_state.sw_cmd = scm_pkg::MGN_HIGH;
					end else if (reg_wdata[scm_pkg::CTRL_CMD_LSB +: 2] == scm_pkg::MGN_LOW) begin
						nxt_state.sw_cmd = scm_pkg::MGN_LOW;
					end else begin
						nxt_state.sw_cmd = scm_pkg::MGN_NOMINAL;
					end
				end
				scm_pkg::REG_MGN_HIGH: begin
					nxt_state.mgn_high = wr_clamped;
				end
				scm_pkg::REG_MGN_LOW: begin
					nxt_state.mgn_low = wr_clamped;
				end
				scm_pkg::REG_RATE: begin
					nxt_state.rate = wr_val;
				end
				scm_pkg::REG_STATUS: begin
					if (reg_wdata[scm_pkg::STS_CLAMP_BIT]) begin
						nxt_state.clamp_flag = 1'b0;
					end
				end
				default: begin
					nxt_state.clamp_flag = state_ff.clamp_flag;
				end
			endcase
		end

		if (reg_wr && running && (reg_addr == scm_pkg::REG_MGN_HIGH || reg_addr == scm_pkg::REG_MGN_LOW)
			&& wr_val > ceiling) begin
			nxt_state.clamp_flag = 1'b1;
		end

		nxt_state.alert = nxt_state.clamp_flag || fault_s;

		if (reg_rd) begin
			case (reg_addr)
				scm_pkg::REG_CTRL: begin
					nxt_state.rdata[scm_pkg::CTRL_SW_EN_BIT] = state_ff.sw_en;
					nxt_state.rdata[scm_pkg::CTRL_CMD_LSB +: 2] = state_ff.sw_cmd;
				end
				scm_pkg::REG_MGN_HIGH: nxt_state.rdata[15:0] = state_ff.mgn_high;
				scm_pkg::REG_MGN_LOW: nxt_state.rdata[15:0] = state_ff.mgn_low;
				scm_pkg::REG_RATE: nxt_state.rdata[15:0] = state_ff.rate;
				scm_pkg::REG_STATUS: nxt_state.rdata = status_word;
				scm_pkg::REG_TARGET: nxt_state.rdata[15:0] = ramp_cur;
				scm_pkg::REG_NOMINAL: nxt_state.rdata[15:0] = state_ff.nominal;
				scm_pkg::REG_STRAP: begin
					nxt_state.rdata[6:0] = state_ff.addr;
					nxt_state.rdata[scm_pkg::STRAP_TRK_LSB +: 4] = state_ff.trk_code;
					nxt_state.rdata[scm_pkg::STRAP_TRK_EN_BIT] = state_ff.trk_en;
				end
				default: nxt_state.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_ff <= '0;
			state_ff.phase <= scm_pkg::PH_SETTLE;
			state_ff.sw_cmd <= scm_pkg::MGN_NOMINAL;
			state_ff.rate <= scm_pkg::RATE_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = state_ff.rdata;
	// shared wired line, pull low
	// Open drain: only ever pulls low
	assign alert_line_o = 1'b0;
	assign alert_line_oe_n = ~state_ff.alert;
	assign target_code = ramp_cur;
	assign target_settled = ramp_at_goal && running;
	assign smbus_addr = state_ff.addr;
	assign strap_valid = running;

	assign track_enable = state_ff.trk_en;
	assign track_ratio_half = state_ff.trk_en && state_ff.trk_code[scm_pkg::TRK_RATIO_BIT];
	assign track_limit_track_reference_input = state_ff.trk_en && state_ff.trk_code[scm_pkg::TRK_LIMIT_BIT];
	// follow down or hold until power-good
	assign track_follow_down = state_ff.trk_en && state_ff.trk_code[scm_pkg::TRK_FOLLOW_BIT];
	assign track_hold_no_decrease = state_ff.trk_en && !state_ff.trk_code[scm_pkg::TRK_FOLLOW_BIT] && !pg_s;
	assign softstart_ignore = state_ff.trk_en;

endmodule
`default_nettype wire

// *** dv/scm_pin_model.sv ***
`default_nettype none
module scm_pin_model (
	input wire logic [1:0] level, // 0 mid, 1 driven high, 2 driven low
	input wire logic alert_line_o, // Alert drive value
	input wire logic alert_line_oe_n, // Alert enable, low drives
	output logic margin_select_hi, // Upper comparator
	output logic margin_select_lo, // Lower comparator
	output logic alert_wire // Resolved alert wire
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Pin levels seen by the block
	// ****************************************
	// three-level comparators
	assign margin_select_hi = (level == 2'h1);
	assign margin_select_lo = (level == 2'h2);
	assign alert_wire = alert_line_oe_n ? 1'b1 : alert_line_o;
endmodule
`default_nettype wire

// *** dv/scm_checker_asserts.sv ***
`default_nettype none
module scm_checker (
	input wire logic core_clk, // System clock
	input wire logic reset, // Async reset
	input wire logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic [15:0] nominal_voltage_strap, // Nominal code
	input wire logic power_good, // Regulation level
	input wire logic fault_event, // Fault level
	input wire logic alert_line_o, // Alert drive
	input wire logic alert_line_oe_n, // Alert enable
	input wire logic [15:0] target_code, // Ramped target
	input wire logic target_settled, // Target at goal
	input wire logic [6:0] smbus_addr, // Device address
	input wire logic strap_valid, // Straps latched
	input wire logic track_enable, // Tracking on
	input wire logic track_follow_down, // Follows down
	input wire logic track_hold_no_decrease, // Hold until good
	input wire logic softstart_ignore // Soft-start unused
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Port relations
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// Nominal strap is held constant by the bench, so the live pin stands for the latched one
	logic [16:0] ceiling;
	assign ceiling = {1'b0, nominal_voltage_strap} + 17'(nominal_voltage_strap / scm_pkg::CEILING_DIV);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside answer cycle");
	a_target_step: assert property (strap_valid && $past(strap_valid) |->
		target_code == $past(target_code) || target_code == $past(target_code) + 16'h0001 ||
		target_code == $past(target_code) - 16'h0001) else $error("target jumped");
	a_target_ceiling: assert property (strap_valid |-> {1'b0, target_code} <= ceiling)
		else $error("target above ceiling");
	a_strap_hold: assert property (strap_valid && $past(strap_valid) |->
		$stable(smbus_addr) && $stable(track_enable)) else $error("latched strap changed");
	a_addr_range: assert property (strap_valid |-> smbus_addr inside {[7'h20:7'h3D]})
		else $error("address out of range");
	a_latch_time: assert property ($fell(reset) |-> ##[90:120] strap_valid)
		else $error("straps not latched in time");
	a_fault_alert: assert property (fault_event [*5] |-> !alert_line_oe_n)
		else $error("fault not on alert");
	a_alert_low: assert property (alert_line_o == 1'b0)
		else $error("alert drives high");
	a_hold_cause: assert property (track_hold_no_decrease |-> track_enable && !track_follow_down)
		else $error("hold without cause");
	a_hold_release: assert property (power_good [*4] |-> !track_hold_no_decrease)
		else $error("hold after power good");
	a_ss_ignore: assert property (strap_valid |-> softstart_ignore == track_enable)
		else $error("soft-start ignore wrong");
	c_alert: cover property (!alert_line_oe_n);
	c_margin_up: cover property (target_settled && target_code > nominal_voltage_strap);
	c_hold: cover property (track_hold_no_decrease);
endmodule
bind scm_top scm_checker i_scm_checker (.core_clk, .reset, .reg_rd, .reg_rdata, .nominal_voltage_strap,
	.power_good, .fault_event, .alert_line_o, .alert_line_oe_n, .target_code, .target_settled, .smbus_addr,
	.strap_valid, .track_enable, .track_follow_down, .track_hold_no_decrease, .softstart_ignore);
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] NOM = 16'h03E8;
	localparam logic [15:0] EXP_HI = NOM + NOM / scm_pkg::MARGIN_DIV;
	localparam logic [15:0] EXP_LO = NOM - NOM / scm_pkg::MARGIN_DIV;
	localparam logic [15:0] CEIL = NOM + NOM / scm_pkg::CEILING_DIV;
	localparam logic [15:0] SW_LO = 16'h0384;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] mgn_level = 2'h0;
	logic [15:0] nominal_voltage_strap = NOM;
	logic [1:0] address_strap_mode = 2'h0;
	logic [4:0] address_strap_rindex = 5'h00;
	logic [3:0] ss_strap_rindex = 4'h0;
	logic [4:0] cfg_strap_rindex = 5'h00;
	logic power_good = 1'b0;
	logic fault_event = 1'b0;
	logic [31:0] reg_rdata;
	logic [15:0] target_code;
	logic [6:0] smbus_addr;
	logic margin_select_hi, margin_select_lo, alert_wire, alert_line_o, alert_line_oe_n;
	logic target_settled, strap_valid, track_enable, track_ratio_half, track_limit_track_reference_input;
	logic track_follow_down, track_hold_no_decrease, softstart_ignore;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	// ****************************************
	// Design, pins and clock
	// ****************************************
	// no enable, registers only
	scm_top i_scm_top (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.margin_select_hi, .margin_select_lo, .nominal_voltage_strap, .address_strap_mode,
		.address_strap_rindex, .ss_strap_rindex, .cfg_strap_rindex, .power_good, .fault_event,
		.alert_line_o, .alert_line_oe_n, .target_code, .target_settled, .smbus_addr, .strap_valid,
		.track_enable, .track_ratio_half, .track_limit_track_reference_input, .track_follow_down,
		.track_hold_no_decrease, .softstart_ignore);
	scm_pin_model i_scm_pin_model (.level(mgn_level), .alert_line_o(alert_line_o),
		.alert_line_oe_n(alert_line_oe_n), .margin_select_hi(margin_select_hi),
		.margin_select_lo(margin_select_lo), .alert_wire(alert_wire));
	always #5 core_clk = ~core_clk;
	// Longest run is a few thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end
	// ****************************************
	// Bus and sequence tasks
	// ****************************************
	task automatic final_report();
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHECK(reg_rdata & mask, exp)
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		for (int i = 0; i < 200 && strap_valid !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		`CHECK(strap_valid, 1'b1)
	endtask
	// Pin changes reach the goal only after the sync delay, so polling starts late
	task automatic wait_settled(input int max);
		repeat (4) @(posedge core_clk);
		#1;
		for (n = 0; n < max && target_settled !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		`CHECK(target_settled, 1'b1)
	endtask
	task automatic margin_pin(input logic [1:0] lvl, input logic [15:0] exp);
		@(posedge core_clk);
		mgn_level <= lvl;
		wait_settled(400);
		`CHECK(target_code, exp)
		rd_check(scm_pkg::REG_TARGET, 32'h0000_FFFF, {16'h0000, exp});
	endtask
	task automatic strap_case(input logic [1:0] m, input logic [4:0] ri, input logic [3:0] ss,
		input logic [4:0] cfg, input logic [6:0] ea, input logic en);
		@(posedge core_clk);
		address_strap_mode <= m;
		address_strap_rindex <= ri;
		ss_strap_rindex <= ss;
		cfg_strap_rindex <= cfg;
		do_reset();
		`CHECK(smbus_addr, ea)
		`CHECK(track_enable, en)
		`CHECK(softstart_ignore, en)
		if (en) begin
			`CHECK(track_ratio_half, ss[2])
			`CHECK(track_limit_track_reference_input, ss[1])
			`CHECK(track_follow_down, ss[0])
			`CHECK(track_hold_no_decrease, ~ss[0])
		end
		rd_check(scm_pkg::REG_STRAP, 32'h0000_1F7F, {19'h0_0000, en, ss, 1'b0, ea});
		@(posedge core_clk);
		address_strap_mode <= ~m;
		address_strap_rindex <= ~ri;
		repeat (5) @(posedge core_clk);
		#1;
		`CHECK(smbus_addr, ea)
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		strap_case(2'h0, 5'h00, 4'h2, 5'h10, 7'h20, 1'b1);
		@(posedge core_clk);
		power_good <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		`CHECK(track_hold_no_decrease, 1'b0)
		@(posedge core_clk);
		power_good <= 1'b0;
		strap_case(2'h1, 5'h00, 4'h5, 5'h03, 7'h21, 1'b0);
		strap_case(2'h2, 5'h00, 4'hD, 5'h0F, 7'h22, 1'b1);
		strap_case(2'h3, 5'h0D, 4'h0, 5'h11, 7'h2D, 1'b1);
		strap_case(2'h3, 5'h1D, 4'h7, 5'h00, 7'h3D, 1'b0);
		strap_case(2'h3, 5'h1F, 4'h9, 5'h01, 7'h3D, 1'b0);
		rd_check(scm_pkg::REG_NOMINAL, 32'h0000_FFFF, {16'h0000, NOM});
		rd_check(scm_pkg::REG_MGN_HIGH, 32'h0000_FFFF, {16'h0000, EXP_HI});
		rd_check(scm_pkg::REG_MGN_LOW, 32'h0000_FFFF, {16'h0000, EXP_LO});
		rd_check(scm_pkg::REG_RATE, 32'h0000_FFFF, 32'h0000_0001);
		rd_check(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		margin_pin(2'h1, EXP_HI);
		margin_pin(2'h2, EXP_LO);
		margin_pin(2'h0, NOM);
		wr(scm_pkg::REG_MGN_HIGH, 32'h0000_07D0);
		rd_check(scm_pkg::REG_MGN_HIGH, 32'h0000_FFFF, {16'h0000, CEIL});
		rd_check(scm_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		`CHECK(alert_wire, 1'b0)
		wr(scm_pkg::REG_STATUS, 32'h0000_0001);
		rd_check(scm_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0000);
		`CHECK(alert_wire, 1'b1)
		margin_pin(2'h1, CEIL);
		margin_pin(2'h0, NOM);
		wr(scm_pkg::REG_MGN_LOW, {16'h0000, SW_LO});
		wr(scm_pkg::REG_RATE, 32'h0000_0004);
		wr(scm_pkg::REG_CTRL, 32'h0000_0005);
		mgn_level <= 2'h1;
		wait_settled(1000);
		`CHECK(target_code, SW_LO)
		`CHECK((n >= 380 && n <= 420), 1'b1)
		rd_check(scm_pkg::REG_STATUS, 32'h0000_0034, 32'h0000_0024);
		wr(scm_pkg::REG_CTRL, 32'h0000_0003);
		wait_settled(1000);
		`CHECK(target_code, CEIL)
		rd_check(scm_pkg::REG_STATUS, 32'h0000_000A, 32'h0000_000A);
		rd_check(scm_pkg::REG_CTRL, 32'h0000_0007, 32'h0000_0003);
		wr(scm_pkg::REG_CTRL, 32'h0000_0001);
		wait_settled(1000);
		`CHECK(target_code, NOM)
		@(posedge core_clk);
		fault_event <= 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		`CHECK(alert_wire, 1'b0)
		rd_check(scm_pkg::REG_STATUS, 32'h0000_0040, 32'h0000_0040);
		@(posedge core_clk);
		fault_event <= 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		`CHECK(alert_wire, 1'b1)
		final_report();
	end
endmodule
`default_nettype wire
